// ===== verilog/ssm_mux_top.v
// Operation
// (R01) bank result: 3-bit status in bits 0-2, six states up to bit 50.
// (R02) each state: 2-bit coding low, then 6-bit column address.
// (R03) per line fifteen bank results arrive, each one status and six states.
// (R04) of the fifteen-by-six states at most nine are kept.
// (R05) two identical half-line reducers each keep nine states and one status.
// (R06) final reducer merges both halves into nine states and one status.
// (R07) line-start reset from sequencer restarts the selection.
// (R08) each sampling strobe selects the next hit state for keeping.
// (R09) latch enable latches the kept states into the output record; a latch_en while the tail holds a record is refused.
// (R10) bank status holds the number of states found in that bank.
// (R11) coding marks up to four contiguous hits from the column address.
// (R12) every kept state carries its 5-bit bank address.
// (R13) beyond nine, states kept in ascending bank order, excess dropped, count reports kept.
// (R14) one readout clock; line-start reset is synchronous to it.

`timescale 1ns/100ps
`default_nettype none

`include "ssm_defs.vh"

module ssm_mux_top #(
    parameter NBANKS = `SSM_BANKS
) (
    input  wire                                 sys_clk,
    input  wire                                 rst_n,
    input  wire                                 line_rst,
    input  wire                                 sample_strobe,
    input  wire                                 latch_en,
    input  wire [NBANKS*`SSM_BANK_RESULT_W-1:0] bank_results,
    output wire                                 line_ready,
    output wire                                 rec_valid,
    input  wire                                 rec_ready,
    output wire [`SSM_STATES_VEC_W-1:0]         rec_states,
    output wire [`SSM_CNT_W-1:0]                rec_count,
    output wire                                 rec_overflow,
    output wire                                 states_left
);

localparam RW  = `SSM_BANK_RESULT_W;
localparam NB0 = `SSM_HALF0_BANKS;
localparam NB1 = NBANKS - `SSM_HALF0_BANKS;
localparam KW  = `SSM_KEPT_W;

////////////////////////////////////////////////////////////////////////////////
// half-line reducers

wire [`SSM_STATES_VEC_W-1:0] h0_states;
wire [`SSM_CNT_W-1:0]        h0_count;
wire                         h0_ovf;
wire                         h0_left;
wire [`SSM_STATES_VEC_W-1:0] h1_states;
wire [`SSM_CNT_W-1:0]        h1_count;
wire                         h1_ovf;
wire                         h1_left;

// both halves sample on the same strobe; bank order survives the merge
// because the lower half always holds banks 0 to 7
ssm_half_reducer #(
    .NB   (NB0),
    .BASE (5'h00)
) u_half0 (                                                              // R05
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .line_rst      (line_rst),
    .sample_strobe (sample_strobe),
    .bank_results  (bank_results[NB0*RW-1:0]),                           // R03
    .kept_states   (h0_states),
    .kept_count    (h0_count),
    .overflow      (h0_ovf),
    .states_left   (h0_left)
);

ssm_half_reducer #(
    .NB   (NB1),
    .BASE (5'h08)
) u_half1 (                                                              // R05
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .line_rst      (line_rst),
    .sample_strobe (sample_strobe),
    .bank_results  (bank_results[NBANKS*RW-1:NB0*RW]),                   // R03
    .kept_states   (h1_states),
    .kept_count    (h1_count),
    .overflow      (h1_ovf),
    .states_left   (h1_left)
);

////////////////////////////////////////////////////////////////////////////////
// final two-to-one reducer

reg  [`SSM_STATES_VEC_W-1:0] merged_states;
reg  [`SSM_CNT_W-1:0]        merged_count;
reg                          merged_ovf;
reg  [`SSM_CNT_W:0]          sum;
integer                      k;
integer                      j;

always @* begin
    merged_states = {`SSM_STATES_VEC_W{1'b0}};
    sum           = {1'b0, h0_count} + {1'b0, h1_count};
    j             = 0;
    for (k = 0; k < `SSM_KEEP; k = k + 1) begin
        j = k - h0_count;
        if (k < h0_count) begin
            merged_states[k*KW +: KW] = h0_states[k*KW +: KW];           // R06
        end else if (j < h1_count) begin
            merged_states[k*KW +: KW] = h1_states[j*KW +: KW];           // R06 R13
        end else begin
            merged_states[k*KW +: KW] = {KW{1'b0}};
        end
    end
    // upper-half states past slot nine are dropped, low banks have priority
    if (sum > {1'b0, `SSM_KEEP}) begin                                   // R13
        merged_count = `SSM_KEEP;
        merged_ovf   = 1'b1;
    end else begin
        merged_count = sum[`SSM_CNT_W-1:0];
        merged_ovf   = h0_ovf | h1_ovf;
    end
end

wire [`SSM_REC_W-1:0] new_rec;

assign new_rec = {merged_ovf, merged_count, merged_states};

////////////////////////////////////////////////////////////////////////////////
// two-entry line buffer toward memory management
// head feeds the outputs directly so every output is a flop; tail only
// fills when memory management stalls with a record already waiting

reg  [`SSM_REC_W-1:0] head_q;
reg  [`SSM_REC_W-1:0] head_d;
reg                   head_v_q;
reg                   head_v_d;
reg  [`SSM_REC_W-1:0] tail_q;
reg  [`SSM_REC_W-1:0] tail_d;
reg                   tail_v_q;
reg                   tail_v_d;
reg                   ready_q;
reg                   left_q;
wire                  push;
wire                  pop;

// a latch while the tail is full is refused; the sequencer sees line_ready low
assign push = latch_en & ~tail_v_q;                                      // R09
assign pop  = head_v_q & rec_ready;

always @* begin
    head_d   = head_q;
    head_v_d = head_v_q;
    tail_d   = tail_q;
    tail_v_d = tail_v_q;
    if (pop) begin
        if (tail_v_q) begin
            head_d = tail_q;
            if (push) begin
                tail_d = new_rec;
            end else begin
                tail_v_d = 1'b0;
            end
        end else if (push) begin
            head_d = new_rec;
        end else begin
            head_v_d = 1'b0;
        end
    end else if (push) begin
        if (!head_v_q) begin
            head_d   = new_rec;                                          // R09
            head_v_d = 1'b1;
        end else begin
            tail_d   = new_rec;
            tail_v_d = 1'b1;
        end
    end
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        head_q   <= {`SSM_REC_W{1'b0}};
        head_v_q <= 1'b0;
        tail_q   <= {`SSM_REC_W{1'b0}};
        tail_v_q <= 1'b0;
        ready_q  <= 1'b0;
        left_q   <= 1'b0;
    end else begin
        head_q   <= head_d;
        head_v_q <= head_v_d;
        tail_q   <= tail_d;
        tail_v_q <= tail_v_d;
        ready_q  <= ~tail_v_d;
        // the flag seen during line_rst belongs to the old line and is stale
        left_q   <= (h0_left | h1_left) & ~line_rst;                     // R07
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

// ready comes up one cycle after reset release
assign line_ready   = ready_q;
assign rec_valid    = head_v_q;
assign rec_states   = head_q[`SSM_STATES_VEC_W-1:0];                     // R11 R12
assign rec_count    = head_q[`SSM_REC_CNT_LSB +: `SSM_CNT_W];
assign rec_overflow = head_q[`SSM_REC_OVF_BIT];
assign states_left  = left_q;

endmodule // ssm_mux_top

`default_nettype wire

// ===== shared/ssm_defs.vh
`ifndef SSM_DEFS_VH
`define SSM_DEFS_VH

// bank result layout
`define SSM_BANKS            15
`define SSM_HALF0_BANKS      8
`define SSM_HALF1_BANKS      7
`define SSM_STATES_PER_BANK  6
`define SSM_BANK_RESULT_W    51
`define SSM_STATUS_LSB       0
`define SSM_STATUS_W         3
`define SSM_STATE0_LSB       3
`define SSM_STATE_W          8
`define SSM_CODE_LSB         0
`define SSM_CODE_W           2
`define SSM_COL_LSB          2
`define SSM_COL_W            6
`define SSM_BANK_ADDR_W      5
`define SSM_MAX_STATUS       3'h6

// kept state: {bank address, column address, coding}
`define SSM_KEPT_W           13
`define SSM_KEEP             4'h9
`define SSM_CNT_W            4
`define SSM_CNT_RST          4'h0

// line record: {overflow, count, 9 kept states}
`define SSM_STATES_VEC_W     117
`define SSM_REC_W            122
`define SSM_REC_CNT_LSB      117
`define SSM_REC_OVF_BIT      121

`endif

// ===== verilog/ssm_half_reducer.v
`timescale 1ns/100ps
`default_nettype none

`include "ssm_defs.vh"

module ssm_half_reducer #(
    parameter                          NB   = 8,
    parameter [`SSM_BANK_ADDR_W-1:0]   BASE = 5'h00
) (
    input  wire                             sys_clk,
    input  wire                             rst_n,
    input  wire                             line_rst,
    input  wire                             sample_strobe,
    input  wire [NB*`SSM_BANK_RESULT_W-1:0] bank_results,
    output wire [`SSM_STATES_VEC_W-1:0]     kept_states,
    output wire [`SSM_CNT_W-1:0]            kept_count,
    output wire                             overflow,
    output wire                             states_left
);

localparam NS = NB*`SSM_STATES_PER_BANK;
localparam RW = `SSM_BANK_RESULT_W;

reg  [NS-1:0]               taken_q;
reg  [`SSM_CNT_W-1:0]       count_q;
reg                         overflow_q;
reg  [`SSM_KEPT_W-1:0]      kept_q [0:`SSM_KEEP-1];
reg  [NS-1:0]               avail;
reg                         found;
reg  [5:0]                  sel_idx;
reg  [`SSM_STATE_W-1:0]     sel_state;
reg  [`SSM_BANK_ADDR_W-1:0] sel_bank;
integer                     i;
integer                     b;
integer                     s;
integer                     bank_i;
integer                     k;

// a corrupt status above six must not open slots that were never stored
function [`SSM_STATUS_W-1:0] stored_states;
    input [`SSM_STATUS_W-1:0] st;
    begin
        stored_states = (st > `SSM_MAX_STATUS) ? `SSM_MAX_STATUS : st;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
always @* begin
    avail = {NS{1'b0}};
    for (b = 0; b < NB; b = b + 1) begin
        for (s = 0; s < `SSM_STATES_PER_BANK; s = s + 1) begin
            avail[b*`SSM_STATES_PER_BANK+s] = (s < stored_states(
                bank_results[b*RW+`SSM_STATUS_LSB +: `SSM_STATUS_W]))    // R10
                & ~taken_q[b*`SSM_STATES_PER_BANK+s];
        end
    end
    found   = 1'b0;
    sel_idx = 6'h00;
    // lowest bank, lowest slot wins
    for (i = NS-1; i >= 0; i = i - 1) begin
        if (avail[i]) begin
            found   = 1'b1;                                              // R13
            sel_idx = i[5:0];
        end
    end
    sel_state = bank_results[(sel_idx/`SSM_STATES_PER_BANK)*RW + `SSM_STATE0_LSB
                + (sel_idx%`SSM_STATES_PER_BANK)*`SSM_STATE_W +: `SSM_STATE_W]; // R01 R02
    bank_i    = BASE + sel_idx/`SSM_STATES_PER_BANK;
    sel_bank  = bank_i[`SSM_BANK_ADDR_W-1:0];                            // R12
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        taken_q    <= {NS{1'b0}};
        count_q    <= `SSM_CNT_RST;
        overflow_q <= 1'b0;
        for (k = 0; k < `SSM_KEEP; k = k + 1) begin
            kept_q[k] <= {`SSM_KEPT_W{1'b0}};
        end
    end else if (line_rst) begin                                         // R07 R14
        taken_q    <= {NS{1'b0}};
        count_q    <= `SSM_CNT_RST;
        overflow_q <= 1'b0;
        for (k = 0; k < `SSM_KEEP; k = k + 1) begin
            kept_q[k] <= {`SSM_KEPT_W{1'b0}};
        end
    end else if (sample_strobe && found) begin                           // R08
        taken_q[sel_idx] <= 1'b1;
        if (count_q < `SSM_KEEP) begin                                   // R04 R05
            kept_q[count_q] <= {sel_bank, sel_state};
            count_q         <= count_q + 4'h1;
        end else begin
            overflow_q <= 1'b1;                                          // R13
        end
    end
end

genvar g;
generate
    for (g = 0; g < 9; g = g + 1) begin : g_flat
        assign kept_states[g*`SSM_KEPT_W +: `SSM_KEPT_W] = kept_q[g];
    end
endgenerate

assign kept_count  = count_q;
assign overflow    = overflow_q;
assign states_left = found;

endmodule // ssm_half_reducer

`default_nettype wire

// ===== sim/ssm_mux_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssm_defs.vh"
module ssm_chk #(
    parameter NBANKS = `SSM_BANKS
) (
    input wire logic                          sys_clk,
    input wire logic                          rst_n,
    input wire logic                          latch_en,
    input wire logic                          line_ready,
    input wire logic                          rec_valid,
    input wire logic                          rec_ready,
    input wire logic [`SSM_STATES_VEC_W-1:0]  rec_states,
    input wire logic [`SSM_CNT_W-1:0]         rec_count,
    input wire logic                          rec_overflow
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    a_rec_hold: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_states)
        && $stable(rec_count) && $stable(rec_overflow)) else $error("record moved while stalled");
    a_latch_answer: assert property (latch_en && line_ready && !rec_valid |=> rec_valid)
        else $error("accepted latch gave no record");
    a_full_stays: assert property (rec_valid && !line_ready && !rec_ready |=> !line_ready)
        else $error("full buffer freed without a pop");
    a_pop_frees: assert property (rec_valid && rec_ready && !line_ready |=> line_ready)
        else $error("pop did not free a slot");
    a_count_max: assert property (rec_valid |-> rec_count <= `SSM_KEEP)
        else $error("more than nine kept");
    a_empty_zero: assert property (rec_valid && rec_count == 4'h0 |-> rec_states == 0)
        else $error("empty record has state bits");
    a_ovf_full: assert property (rec_valid && rec_overflow |-> rec_count == `SSM_KEEP)
        else $error("overflow without full record");
    a_bank_addr: assert property (rec_valid && rec_count != 4'h0 |-> rec_states[12:8] < NBANKS)
        else $error("bank address out of range");
endmodule // ssm_chk
bind ssm_mux_top ssm_chk #(.NBANKS(NBANKS)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .latch_en(latch_en), .line_ready(line_ready), .rec_valid(rec_valid),
    .rec_ready(rec_ready), .rec_states(rec_states), .rec_count(rec_count),
    .rec_overflow(rec_overflow));
`default_nettype wire

// ===== sim/ssm_mem_sink.sv
`timescale 1ns/100ps
`default_nettype none
module ssm_mem_sink (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hold,
    output var logic rec_ready
);
    // registered so the take signal only moves just after a clock edge
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rec_ready <= 1'b0;
        end else begin
            rec_ready <= !hold;
        end
    end
endmodule // ssm_mem_sink
`default_nettype wire

// ===== sim/ssm_mux_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssm_defs.vh"
module ssm_mux_top_bench;
    localparam W = `SSM_BANK_RESULT_W;
    logic                       sys_clk       = 1'b0;
    logic                       rst_n         = 1'b0;
    logic                       line_rst      = 1'b0;
    logic                       sample_strobe = 1'b0;
    logic                       latch_en      = 1'b0;
    logic                       hold          = 1'b1;
    logic [`SSM_BANKS*W-1:0]    br            = '0;
    logic [`SSM_REC_W-1:0]      ex;
    wire                        line_ready;
    wire                        rec_valid;
    wire                        rec_ready;
    wire [`SSM_STATES_VEC_W-1:0] rec_states;
    wire [`SSM_CNT_W-1:0]       rec_count;
    wire                        rec_overflow;
    wire                        states_left;
    int                         bad_count = 0;
    int                         checks    = 0;
    always #12.5 sys_clk = ~sys_clk;
    ssm_mux_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .line_rst(line_rst),
        .sample_strobe(sample_strobe), .latch_en(latch_en), .bank_results(br),
        .line_ready(line_ready), .rec_valid(rec_valid), .rec_ready(rec_ready),
        .rec_states(rec_states), .rec_count(rec_count), .rec_overflow(rec_overflow),
        .states_left(states_left));
    ssm_mem_sink u_sink (.sys_clk(sys_clk), .rst_n(rst_n), .hold(hold), .rec_ready(rec_ready));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic [12:0] ks(input int b, input int s);
        ks = {5'(b), 8'(b * 16 + s + 1)};
    endfunction
    task automatic setb(input int b, input int n);
        br[b*W +: 3] = n[2:0];
        for (int s = 0; s < 6; s++) br[b*W+3+8*s +: 8] = 8'(b * 16 + s + 1);
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task cmpr(input logic [`SSM_REC_W-1:0] e);
        checks++;
        if ({rec_overflow, rec_count, rec_states} !== e) begin
            $display("[FAIL] %0t got %h exp %h", $time, {rec_overflow, rec_count, rec_states}, e);
            bad_count++;
        end
    endtask
    task cmpb(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
            bad_count++;
        end
    endtask
    // bounded: a record that never shows ends the run
    task waitv;
        for (int i = 0; i < 20 && rec_valid !== 1'b1; i++) @(negedge sys_clk);
        if (rec_valid !== 1'b1) begin
            bad_count++;
            results;
        end
    endtask
    task lrst;
        line_rst = 1'b1;
        @(negedge sys_clk) line_rst = 1'b0;
    endtask
    task strb(input int n);
        sample_strobe = 1'b1;
        repeat (n) @(negedge sys_clk);
        sample_strobe = 1'b0;
    endtask
    task lat;
        latch_en = 1'b1;
        @(negedge sys_clk) latch_en = 1'b0;
    endtask
    task pop;
        hold = 1'b0;
        @(negedge sys_clk) hold = 1'b1;
        repeat (2) @(negedge sys_clk);
    endtask
    task exp_three;
        ex = '0;
        ex[12:0] = ks(0, 0);
        ex[25:13] = ks(0, 1);
        ex[38:26] = ks(9, 0);
        ex[120:117] = 4'h3;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_buffer;
        br = '0;
        setb(0, 2);
        setb(9, 1);
        lrst;
        strb(1);
        lat;
        strb(1);
        lat;
        cmpb(line_ready, 1'b0);
        @(negedge sys_clk);
        lat;
        waitv;
        ex = '0;
        ex[12:0] = ks(0, 0);
        ex[25:13] = ks(9, 0);
        ex[120:117] = 4'h2;
        cmpr(ex);
        pop;
        exp_three;
        cmpr(ex);
        cmpb(line_ready, 1'b1);
        pop;
        cmpb(rec_valid, 1'b0);
        $display("test buffer done");
    endtask
    task t_over;
        for (int b = 0; b < `SSM_BANKS; b++) setb(b, 6);
        // a status above six must still yield exactly six slots
        setb(0, 7);
        lrst;
        strb(9);
        cmpb(states_left, 1'b1);
        lat;
        waitv;
        ex = '0;
        for (int k = 0; k < 9; k++) ex[k*13 +: 13] = ks(k / 6, k % 6);
        ex[120:117] = 4'h9;
        ex[121] = 1'b1;
        cmpr(ex);
        pop;
        $display("test overflow done");
    endtask
    task t_restart;
        br = '0;
        setb(0, 2);
        setb(9, 1);
        lrst;
        strb(5);
        cmpb(states_left, 1'b0);
        lat;
        waitv;
        exp_three;
        cmpr(ex);
        pop;
        lrst;
        lat;
        waitv;
        cmpr('0);
        pop;
        $display("test restart done");
    endtask
    initial begin
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_buffer;
        t_over;
        t_restart;
        results;
    end
endmodule // ssm_mux_top_bench
`default_nettype wire
